// *** verilog/tx_port_cfg_pkg.sv ***
// Shared constants, types and decode helpers for the per-port transmit configuration bank.
// Assumes one 100 MHz clock domain and a 32-bit AXI4-Lite register bus with 16-bit byte addresses.
package tx_port_cfg_pkg;

    // Register word indices inside one port window (byte address is four times the index).
    localparam logic [8:0]  IDX_FIFO_CTRL   = 9'h187;   // Transmit HDLC FIFO control.
    localparam logic [8:0]  IDX_IBO_CTRL    = 9'h188;   // Interleave bus control.
    localparam logic [8:0]  IDX_MON_SEL     = 9'h189;   // Transmit time-slot monitor select.
    localparam logic [8:0]  IDX_TP_CTRL     = 9'h18A;   // Transmit test-pattern port control.

    // Port window strides in word indices; they are single address bits, used below by position.
    localparam logic [13:0] PORT_STRIDE_IDX  = 14'h0200; // One port further on.
    localparam logic [13:0] GROUP_STRIDE_IDX = 14'h2000; // Extra step for ports nine to sixteen.
    localparam int          PORT_LSB         = 9;        // Index bit of the port stride.
    localparam int          PORT_MSB         = 12;       // Top bit of the port number.
    localparam int          GROUP_BIT        = 13;       // Index bit of the group stride.

    // Bus and register widths.
    localparam int          ADDR_W = 16;
    localparam int          DATA_W = 32;
    localparam int          REG_W  = 8;

    // Field positions.
    localparam int          WM_LSB          = 0;
    localparam int          MODE_BIT        = 4;
    localparam int          BUS_EN_BIT      = 3;
    localparam int          CHAN_LSB        = 0;
    localparam int          TP_EN_BIT       = 0;
    localparam int          TP_UNFRAMED_BIT = 1;
    localparam int          TP_DIR_BIT      = 2;

    // FIFO low-watermark thresholds in bytes, per select code.
    localparam logic [5:0]  WM_BYTES_0 = 6'h04;
    localparam logic [5:0]  WM_BYTES_1 = 6'h10;
    localparam logic [5:0]  WM_BYTES_2 = 6'h20;
    localparam logic [5:0]  WM_BYTES_3 = 6'h30;
    localparam logic [5:0]  CHAN_BASE  = 6'h01;      // Selector zero names channel one.

    // Bus responses.
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Which register an access lands on.
    typedef enum logic [2:0] {SEL_NONE, SEL_FIFO, SEL_IBO, SEL_MON, SEL_TP} reg_sel_t;

    // One port's configuration, all fields reset to zero.
    typedef struct packed {
        logic [1:0] tx_fifo_low_watermark_sel;
        logic       interleave_mode_sel;
        logic       interleave_bus_en;
        logic [4:0] tx_monitor_channel_sel;
        logic       test_pattern_direction_sel;
        logic       test_pattern_unframed_sel;
        logic       test_pattern_port_en;
    } port_cfg_t;

    // Result of address decoding.
    typedef struct packed {
        logic       hit;
        logic [3:0] port;
        reg_sel_t   sel;
    } addr_dec_t;

    // Bus slave state.
    typedef struct packed {
        logic              aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_held;
        logic [REG_W-1:0]  w_byte;
        logic              w_lane0;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
    } slave_state_t;

    // Decoded values that feed the transmit datapath.
    typedef struct packed {
        logic [5:0] fifo_threshold;
        logic [5:0] monitor_channel;
    } cfg_decode_t;

    // Maps a byte address onto port and register; misaligned or foreign addresses miss.
    function automatic addr_dec_t decode_addr(input logic [ADDR_W-1:0] a, input int num_ports);
        addr_dec_t   d;
        logic [13:0] idx;
        idx    = a[ADDR_W-1:2];
        d.port = idx[PORT_MSB:PORT_LSB];
        d.sel  = SEL_NONE;
        unique case (idx[PORT_LSB-1:0])
            IDX_FIFO_CTRL: d.sel = SEL_FIFO;
            IDX_IBO_CTRL:  d.sel = SEL_IBO;
            IDX_MON_SEL:   d.sel = SEL_MON;
            IDX_TP_CTRL:   d.sel = SEL_TP;
            default:       d.sel = SEL_NONE;
        endcase
        // The group bit must agree with the port number's top bit, or the address falls in a hole.
        d.hit = (a[1:0] == 2'h0) && (idx[GROUP_BIT] == idx[PORT_MSB]) && (d.sel != SEL_NONE)
                && (int'(d.port) < num_ports);
        return d;
    endfunction

    // Read image of one register; reserved bits read as zero.
    function automatic logic [REG_W-1:0] reg_image(input port_cfg_t c, input reg_sel_t s);
        logic [REG_W-1:0] v;
        v = '0;
        unique case (s)
            SEL_FIFO: v[WM_LSB +: 2] = c.tx_fifo_low_watermark_sel;
            SEL_IBO: begin
                v[MODE_BIT]   = c.interleave_mode_sel;
                v[BUS_EN_BIT] = c.interleave_bus_en;
            end
            SEL_MON:  v[CHAN_LSB +: 5] = c.tx_monitor_channel_sel;
            SEL_TP: begin
                v[TP_EN_BIT]       = c.test_pattern_port_en;
                v[TP_UNFRAMED_BIT] = c.test_pattern_unframed_sel;
                v[TP_DIR_BIT]      = c.test_pattern_direction_sel;
            end
            default: v = '0;
        endcase
        return v;
    endfunction

endpackage

// *** verilog/port_cfg_regs.sv ***
// One port's copy of the transmit configuration registers.
// Assumes the bus slave above it presents at most one single-cycle write strobe per access.
`timescale 1ns/1ps
module port_cfg_regs
    import tx_port_cfg_pkg::*;
(
    // Clock and reset.
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Write strobe from the bus slave.
    input  wire logic             wr_en,
    input  wire reg_sel_t         wr_sel,
    input  wire logic [REG_W-1:0] wr_byte,
    // Configuration towards the transmit datapath.
    output port_cfg_t             cfg
);

    port_cfg_t state_r;   // All state of this port.
    port_cfg_t state_nxt; // Next value.

    // Only the defined fields are stored, so reserved bits can never hold a written value.
    always_comb begin
        state_nxt = state_r;
        if (wr_en) begin
            unique case (wr_sel)
                SEL_FIFO: state_nxt.tx_fifo_low_watermark_sel = wr_byte[WM_LSB +: 2];
                SEL_IBO: begin
                    state_nxt.interleave_mode_sel = wr_byte[MODE_BIT];
                    state_nxt.interleave_bus_en   = wr_byte[BUS_EN_BIT];
                end
                SEL_MON:  state_nxt.tx_monitor_channel_sel = wr_byte[CHAN_LSB +: 5];
                SEL_TP: begin
                    state_nxt.test_pattern_port_en       = wr_byte[TP_EN_BIT];
                    state_nxt.test_pattern_unframed_sel  = wr_byte[TP_UNFRAMED_BIT];
                    state_nxt.test_pattern_direction_sel = wr_byte[TP_DIR_BIT];
                end
                default: state_nxt = state_r;
            endcase
        end
    end

    // Synchronous reset clears every field.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign cfg = state_r;

endmodule

// *** verilog/tx_cfg_decode.sv ***
// Registered decode of one port's selects into the values the transmit datapath uses.
// Assumes its configuration input comes from registers on the same clock.
`timescale 1ns/1ps
module tx_cfg_decode
    import tx_port_cfg_pkg::*;
(
    // Clock and reset.
    input  wire logic      aclk,
    input  wire logic      aresetn,
    // Configuration of this port.
    input  wire port_cfg_t cfg,
    // Decoded values, one cycle behind the configuration.
    output cfg_decode_t    dec
);

    cfg_decode_t state_r;   // All state of this decoder.
    cfg_decode_t state_nxt; // Next value.

    // Watermark code to byte count, and zero-based selector to one-based channel number.
    always_comb begin
        state_nxt = state_r;
        unique case (cfg.tx_fifo_low_watermark_sel)
            2'h0: state_nxt.fifo_threshold = WM_BYTES_0;
            2'h1: state_nxt.fifo_threshold = WM_BYTES_1;
            2'h2: state_nxt.fifo_threshold = WM_BYTES_2;
            2'h3: state_nxt.fifo_threshold = WM_BYTES_3;
        endcase
        state_nxt.monitor_channel = 6'({1'b0, cfg.tx_monitor_channel_sel}) + CHAN_BASE;
    end

    // Reset values match the zero selects: four bytes and channel one.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= '{fifo_threshold: WM_BYTES_0, monitor_channel: CHAN_BASE};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign dec = state_r;

endmodule

// *** verilog/tx_port_cfg_regs.sv ***
// Transmit configuration register bank for all ports, reached over AXI4-Lite.
// Assumes an AXI4-Lite master on aclk; FIFO, interleave bus, monitor and pattern logic sit outside.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
module tx_port_cfg_regs
    import tx_port_cfg_pkg::*;
#(
    parameter int NUM_PORTS = 16
) (
    // Clock and reset.
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    // AXI4-Lite write address channel.
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    input  wire logic [ADDR_W-1:0]               s_axi_awaddr,
    input  wire logic [2:0]                      s_axi_awprot,
    // AXI4-Lite write data channel.
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    input  wire logic [DATA_W-1:0]               s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    // AXI4-Lite write response channel.
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    output logic [1:0]                           s_axi_bresp,
    // AXI4-Lite read address channel.
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    input  wire logic [ADDR_W-1:0]               s_axi_araddr,
    input  wire logic [2:0]                      s_axi_arprot,
    // AXI4-Lite read data channel.
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    output logic [DATA_W-1:0]                    s_axi_rdata,
    output logic [1:0]                           s_axi_rresp,
    // Per-port configuration towards the transmit datapath.
    output port_cfg_t   [NUM_PORTS-1:0]          port_cfg,
    output cfg_decode_t [NUM_PORTS-1:0]          port_dec
);

    slave_state_t state_r;   // All state of the bus slave.
    slave_state_t state_nxt; // Next value.

    addr_dec_t        wr_dec;  // Decode of the held write address.
    addr_dec_t        rd_dec;  // Decode of the offered read address.
    logic             aw_fire; // Write address taken this cycle.
    logic             w_fire;  // Write data taken this cycle.
    logic             ar_fire; // Read address taken this cycle.
    logic             wr_go;   // Both halves of a write are held; commit now.
    logic             wr_en;   // Register write strobe, only for mapped addresses with lane 0.
    logic [REG_W-1:0] rd_byte; // Read image of the addressed register.

    // Protection bits carry no meaning here; all accesses are treated alike.
    logic unused_prot;
    assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[DATA_W-1:REG_W], s_axi_wstrb[3:1]};

    // Handshakes. New write halves are refused while a response waits, which keeps one write in flight.
    assign s_axi_awready = !state_r.aw_held && !state_r.bvalid;
    assign s_axi_wready  = !state_r.w_held && !state_r.bvalid;
    assign s_axi_arready = !state_r.rvalid;
    assign aw_fire       = s_axi_awvalid && s_axi_awready;
    assign w_fire        = s_axi_wvalid && s_axi_wready;
    assign ar_fire       = s_axi_arvalid && s_axi_arready;
    assign wr_go         = state_r.aw_held && state_r.w_held;

    // Address decoding shares one function between the write and read paths.
    assign wr_dec = decode_addr(state_r.aw_addr, NUM_PORTS);
    assign rd_dec = decode_addr(s_axi_araddr, NUM_PORTS);

    // A write with lane 0 off is answered but stores nothing, since every field lives in lane 0.
    assign wr_en = wr_go && wr_dec.hit && state_r.w_lane0;

    // Read image of the addressed port; the port field is only trusted when the address hits.
    always_comb begin
        rd_byte = '0;
        if (rd_dec.hit) begin
            rd_byte = reg_image(port_cfg[rd_dec.port], rd_dec.sel);
        end
    end

    // Bus slave next-state logic.
    always_comb begin
        state_nxt = state_r;
        // Capture the write address and the write data independently, in either order.
        if (aw_fire) begin
            state_nxt.aw_held = 1'b1;
            state_nxt.aw_addr = s_axi_awaddr;
        end
        if (w_fire) begin
            state_nxt.w_held  = 1'b1;
            state_nxt.w_byte  = s_axi_wdata[REG_W-1:0];
            state_nxt.w_lane0 = s_axi_wstrb[0];
        end
        // Once both are held, the registers take the byte and the response is raised together.
        if (wr_go) begin
            state_nxt.aw_held = 1'b0;
            state_nxt.w_held  = 1'b0;
            state_nxt.bvalid  = 1'b1;
            state_nxt.bresp   = wr_dec.hit ? RESP_OKAY : RESP_SLVERR;
        end else if (state_r.bvalid && s_axi_bready) begin
            state_nxt.bvalid = 1'b0;
        end
        // Reads answer one cycle after the address is taken; holes answer zero with an error.
        if (ar_fire) begin
            state_nxt.rvalid = 1'b1;
            state_nxt.rdata  = DATA_W'(rd_byte);
            state_nxt.rresp  = rd_dec.hit ? RESP_OKAY : RESP_SLVERR;
        end else if (state_r.rvalid && s_axi_rready) begin
            state_nxt.rvalid = 1'b0;
        end
    end

    // Bus slave state register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Response outputs come straight from the state register.
    assign s_axi_bvalid = state_r.bvalid;
    assign s_axi_bresp  = state_r.bresp;
    assign s_axi_rvalid = state_r.rvalid;
    assign s_axi_rdata  = state_r.rdata;
    assign s_axi_rresp  = state_r.rresp;

    // One register copy and one decoder for each port; only the addressed copy sees the strobe.
    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        port_cfg_regs u_regs (
            .aclk    (aclk),
            .aresetn (aresetn),
            .wr_en   (wr_en && (wr_dec.port == 4'(p))),
            .wr_sel  (wr_dec.sel),
            .wr_byte (state_r.w_byte),
            .cfg     (port_cfg[p])
        );

        tx_cfg_decode u_dec (
            .aclk    (aclk),
            .aresetn (aresetn),
            .cfg     (port_cfg[p]),
            .dec     (port_dec[p])
        );

        // The largest watermark code must give the largest threshold one cycle later.
        a_wm_largest: assert property (@(posedge aclk) disable iff (!aresetn)
            (port_cfg[p].tx_fifo_low_watermark_sel == 2'h3) |=> (port_dec[p].fifo_threshold == 6'h30))
            else $error("watermark code 3 did not give 48 bytes");

        // The smallest code must give four bytes.
        a_wm_smallest: assert property (@(posedge aclk) disable iff (!aresetn)
            (port_cfg[p].tx_fifo_low_watermark_sel == 2'h0) |=> (port_dec[p].fifo_threshold == 6'h04))
            else $error("watermark code 0 did not give 4 bytes");

        // A write of the interleave register takes the mode bit from bit 4 of the data.
        a_mode_write: assert property (@(posedge aclk) disable iff (!aresetn)
            (wr_en && wr_dec.port == 4'(p) && wr_dec.sel == SEL_IBO)
            |=> (port_cfg[p].interleave_mode_sel == $past(state_r.w_byte[4])))
            else $error("interleave mode bit not taken from data bit 4");

        // The bus enable follows bit 3 of the same write.
        a_bus_en_write: assert property (@(posedge aclk) disable iff (!aresetn)
            (wr_en && wr_dec.port == 4'(p) && wr_dec.sel == SEL_IBO)
            |=> (port_cfg[p].interleave_bus_en == $past(state_r.w_byte[3])))
            else $error("interleave bus enable not taken from data bit 3");

        // The channel selector takes the low five bits.
        a_chan_write: assert property (@(posedge aclk) disable iff (!aresetn)
            (wr_en && wr_dec.port == 4'(p) && wr_dec.sel == SEL_MON)
            |=> (port_cfg[p].tx_monitor_channel_sel == $past(state_r.w_byte[4:0])))
            else $error("monitor selector not taken from data bits 4 to 0");

        // Selector all ones names channel 32 on the following cycle.
        a_chan_number: assert property (@(posedge aclk) disable iff (!aresetn)
            (port_cfg[p].tx_monitor_channel_sel == 5'h1F) |=> (port_dec[p].monitor_channel == 6'h20))
            else $error("selector all ones did not name channel 32");

        // A write aimed elsewhere leaves this port untouched.
        a_port_isolate: assert property (@(posedge aclk) disable iff (!aresetn)
            (wr_go && !(wr_dec.hit && wr_dec.port == 4'(p))) |=> $stable(port_cfg[p]))
            else $error("write changed a port it was not addressed to");

        // The pattern port control bits follow bits 0, 1 and 2.
        a_tp_en_write: assert property (@(posedge aclk) disable iff (!aresetn)
            (wr_en && wr_dec.port == 4'(p) && wr_dec.sel == SEL_TP)
            |=> (port_cfg[p].test_pattern_port_en == $past(state_r.w_byte[0])))
            else $error("pattern port enable not taken from data bit 0");

        a_tp_frame_write: assert property (@(posedge aclk) disable iff (!aresetn)
            (wr_en && wr_dec.port == 4'(p) && wr_dec.sel == SEL_TP)
            |=> (port_cfg[p].test_pattern_unframed_sel == $past(state_r.w_byte[1])))
            else $error("unframed select not taken from data bit 1");

        a_tp_dir_write: assert property (@(posedge aclk) disable iff (!aresetn)
            (wr_en && wr_dec.port == 4'(p) && wr_dec.sel == SEL_TP)
            |=> (port_cfg[p].test_pattern_direction_sel == $past(state_r.w_byte[2])))
            else $error("direction select not taken from data bit 2");

        // Reset must clear the whole copy, so this one is not disabled by reset.
        a_reset_clear: assert property (@(posedge aclk) disable iff (1'b0)
            !aresetn |=> (port_cfg[p] == '0))
            else $error("port configuration not zero after reset");
    end

    // Reserved bits of the interleave register read as zero.
    a_rd_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
        (ar_fire && rd_dec.sel == SEL_IBO) |=> (s_axi_rvalid && s_axi_rdata[31:5] == '0
        && s_axi_rdata[2:0] == 3'h0))
        else $error("reserved interleave bits read as nonzero");

    // A held write pair must be answered on the next cycle.
    a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_go |=> s_axi_bvalid)
        else $error("write not answered one cycle after both halves held");

    // Main scenarios worth seeing in simulation.
    c_last_port_ibo: cover property (@(posedge aclk) disable iff (!aresetn)
        wr_en && wr_dec.port == 4'(NUM_PORTS - 1) && wr_dec.sel == SEL_IBO);
    c_read_hole: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
    c_channel_32: cover property (@(posedge aclk) disable iff (!aresetn)
        port_dec[0].monitor_channel == 6'h20);
    c_frame_bus: cover property (@(posedge aclk) disable iff (!aresetn)
        port_cfg[0].interleave_bus_en && port_cfg[0].interleave_mode_sel);

endmodule

// *** test/tx_port_cfg_regs_tb.sv ***
// Self-checking bench for the transmit port configuration bank, driven over AXI4-Lite.
// Assumes the bank's package and modules are compiled first; no partner model is needed.
`timescale 1ns/1ps
module tx_port_cfg_regs_tb
    import tx_port_cfg_pkg::*;
();
    // Clock, reset and bus wires.
    logic               aclk    = 1'b0;
    logic               aresetn = 1'b0;
    logic               awv, wv, br, arv, rr, awr, wrdy, bv, arr, rv;
    logic [15:0]        awa, ara;
    logic [31:0]        wd, rd, got;
    logic [3:0]         st;
    logic [1:0]         bresp, rresp, rsp;
    port_cfg_t   [15:0] cfg;
    cfg_decode_t [15:0] dec;
    int                 fails, n_tests;
    // Byte thresholds per watermark code, and write patterns with reserved bits set.
    logic [5:0]         thr [4] = '{6'h04, 6'h10, 6'h20, 6'h30};
    logic [7:0]         pat [3] = '{8'hFF, 8'h12, 8'h0D};

    tx_port_cfg_regs #(.NUM_PORTS(16)) i_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(st),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .port_cfg(cfg), .port_dec(dec));

    // The clock toggles every half period of 5 ns.
    always #5 aclk = ~aclk;

    // Byte address of a register index in port n, groups of eight ports one stride apart.
    function automatic logic [15:0] ba(input int n, input logic [8:0] i);
        return 16'(4 * (int'(i) + 32'h0000_0200 * (n - 1) + 32'h0000_2000 * ((n - 1) / 8)));
    endfunction

    // Monitor selector written to port n; port 1 gets zero and port 16 gets the top code.
    function automatic logic [4:0] mv(input int n);
        return 5'(2 * n - 2 + int'(n == 16));
    endfunction

    // One write; handshakes are judged on values settled after the previous edge.
    task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ah, wh, bh;
        bh = 1'b0;
        @(posedge aclk);
        awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; br <= 1'b1;
        while (!bh) begin
            #1;
            ah = awv && awr; wh = wv && wrdy; bh = bv && br;
            if (bh) r = bresp;
            @(posedge aclk);
            if (ah) awv <= 1'b0;
            if (wh) wv <= 1'b0;
            if (bh) br <= 1'b0;
        end
    endtask

    // One read, held until the data handshake.
    task automatic rdt(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah, dh;
        dh = 1'b0;
        @(posedge aclk);
        arv <= 1'b1; ara <= a; rr <= 1'b1;
        while (!dh) begin
            #1;
            ah = arv && arr; dh = rv && rr;
            if (dh) begin d = rd; r = rresp; end
            @(posedge aclk);
            if (ah) arv <= 1'b0;
            if (dh) rr <= 1'b0;
        end
    endtask

    // Compare tasks for data values and for bus responses.
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin fails++; $display("wrong value %s expected %h seen %h", nm, e, g); end
    endtask
    task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        n_tests++;
        if (g !== e) begin fails++; $display("wrong value %s expected %h seen %h", nm, e, g); end
    endtask
    task automatic rchk(input string nm, input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
        rdt(a, got, rsp); chk(nm, e, got); chk_resp(nm, er, rsp);
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence: reset, field behaviour, port strides, refusals, second reset.
    initial begin
        {awv, wv, br, arv, rr} = '0; awa = '0; ara = '0; wd = '0; st = 4'hF; fails = 0; n_tests = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 4; k++) rchk("reset read", ba(1, IDX_FIFO_CTRL + 9'(k)), 32'h0000_0000, RESP_OKAY);
        chk("reset threshold", 32'h0000_0004, 32'(dec[0].fifo_threshold));
        chk("reset channel", 32'h0000_0001, 32'(dec[0].monitor_channel));
        $display("test reset done");
        // Every watermark code; reserved bits are written high and must read back low.
        for (int k = 0; k < 4; k++) begin
            wr(ba(1, IDX_FIFO_CTRL), 32'hFFFF_FFFC | 32'(k), rsp);
            repeat (2) @(posedge aclk);
            chk("threshold", 32'(thr[k]), 32'(dec[0].fifo_threshold));
            rchk("fifo ctrl", ba(1, IDX_FIFO_CTRL), 32'(k), RESP_OKAY);
        end
        // Interleave and test-pattern bits, each value seen both set and clear.
        for (int k = 0; k < 3; k++) begin
            wr(ba(1, IDX_IBO_CTRL), {24'hFF_FFFF, pat[k]}, rsp);
            wr(ba(1, IDX_TP_CTRL), {24'hFF_FFFF, pat[k]}, rsp);
            chk("mode", 32'(pat[k][4]), 32'(cfg[0].interleave_mode_sel));
            chk("bus en", 32'(pat[k][3]), 32'(cfg[0].interleave_bus_en));
            chk("tp en", 32'(pat[k][0]), 32'(cfg[0].test_pattern_port_en));
            chk("tp unframed", 32'(pat[k][1]), 32'(cfg[0].test_pattern_unframed_sel));
            chk("tp dir", 32'(pat[k][2]), 32'(cfg[0].test_pattern_direction_sel));
            rchk("ibo ctrl", ba(1, IDX_IBO_CTRL), 32'(pat[k] & 8'h18), RESP_OKAY);
            rchk("tp ctrl", ba(1, IDX_TP_CTRL), 32'(pat[k] & 8'h07), RESP_OKAY);
        end
        $display("test fields done");
        // A distinct selector in every port, checked only after all are written.
        for (int n = 1; n <= 16; n++) wr(ba(n, IDX_MON_SEL), 32'hFFFF_FFE0 | 32'(mv(n)), rsp);
        repeat (2) @(posedge aclk);
        for (int n = 1; n <= 16; n++) begin
            chk("selector", 32'(mv(n)), 32'(cfg[n-1].tx_monitor_channel_sel));
            chk("channel", 32'(mv(n)) + 32'h0000_0001, 32'(dec[n-1].monitor_channel));
            rchk("mon sel", ba(n, IDX_MON_SEL), 32'(mv(n)), RESP_OKAY);
        end
        $display("test ports done");
        // A hole between groups and an unused index are refused; a write without lane 0 is ignored.
        wr(16'h4620, 32'h0000_00FF, rsp);
        chk_resp("hole write", RESP_SLVERR, rsp);
        // Port 9 still holds only the selector written in the port test; its other fields stay zero.
        chk("hole effect", 32'({mv(9), 3'h0}), 32'(cfg[8]));
        rchk("hole read", 16'h4620, 32'h0000_0000, RESP_SLVERR);
        rchk("unused read", ba(1, 9'h18B), 32'h0000_0000, RESP_SLVERR);
        st <= 4'hE;
        wr(ba(1, IDX_TP_CTRL), 32'h0000_0007, rsp);
        st <= 4'hF;
        chk_resp("no lane write", RESP_OKAY, rsp);
        rchk("no lane read", ba(1, IDX_TP_CTRL), 32'h0000_0005, RESP_OKAY);
        // Reset again in mid-run; every field returns to zero.
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("rereset tp", ba(1, IDX_TP_CTRL), 32'h0000_0000, RESP_OKAY);
        rchk("rereset mon", ba(16, IDX_MON_SEL), 32'h0000_0000, RESP_OKAY);
        chk("rereset channel", 32'h0000_0001, 32'(dec[15].monitor_channel));
        $display("test refusals done");
        end_of_test();
    end

    // Watchdog well beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        end_of_test();
    end
endmodule
